/* cmvr_clock_monitor_volume_ramp.sv */
/*
  clock detect status register and shared digital volume with a
  programmable ramp toward the written volume code.
  assumes a register port on the same clock, detector levels from
  neighbouring units on the same clock, and a one-cycle sample tick.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmvr_params.svh"

module cmvr_clock_monitor_volume_ramp (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic bclk_rate_err,
  input wire logic pll_over_rate,
  input wire logic pll_enabled,
  input wire logic pll_locked,
  input wire logic bclk_missing,
  input wire logic bclk_ratio_stable,
  input wire logic [9:0] bclk_ratio,
  input wire logic fs_auto_mode,
  input wire logic fs_rate_invalid,
  input wire logic fs_cfg_mismatch,
  output logic [7:0] applied_volume,
  output logic volume_ramping
);
  import cmvr_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [7:0] step_units(input logic [1:0] sel);
    unique case (sel)
      2'b00: step_units = 8'h08;
      2'b01: step_units = 8'h04;
      2'b10: step_units = 8'h02;
      2'b11: step_units = 8'h01;
    endcase
  endfunction

  function automatic logic [1:0] interval_last(input logic [1:0] sel);
    unique case (sel)
      2'b00: interval_last = 2'd0;
      2'b01: interval_last = 2'd1;
      2'b10: interval_last = 2'd3;
      2'b11: interval_last = 2'd0;
    endcase
  endfunction

  cmvr_state_t s_q;
  cmvr_state_t s_d;
  logic [1:0] fall_int;
  logic [1:0] fall_stp;
  logic [1:0] rise_int;
  logic [1:0] rise_stp;
  logic falling;
  logic rising;
  logic [1:0] cur_int;
  logic [7:0] gap;
  logic [7:0] step;
  logic update;

  assign fall_int = s_q.ramp_cfg[`CMVR_POS_FALL_INTERVAL +: 2];
  assign fall_stp = s_q.ramp_cfg[`CMVR_POS_FALL_STEP +: 2];
  assign rise_int = s_q.ramp_cfg[`CMVR_POS_RISE_INTERVAL +: 2];
  assign rise_stp = s_q.ramp_cfg[`CMVR_POS_RISE_STEP +: 2];
  // higher code means lower gain
  assign falling = s_q.volume_code > s_q.applied;
  assign rising = s_q.volume_code < s_q.applied;
  assign cur_int = falling ? fall_int : rise_int;
  assign gap = falling ? 8'(s_q.volume_code - s_q.applied) : 8'(s_q.applied - s_q.volume_code);
  assign step = falling ? step_units(fall_stp) : step_units(rise_stp);
  assign update = sample_tick && (s_q.tick_cnt == interval_last(cur_int));

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    // detect flags follow live detector levels
    s_d.flags = 8'h00;
    s_d.flags[`CMVR_BIT_BCLK_RATE_ERR] = bclk_rate_err;
    s_d.flags[`CMVR_BIT_PLL_OVER_RATE] = pll_over_rate;
    s_d.flags[`CMVR_BIT_PLL_LOCKED] = pll_enabled && pll_locked;
    s_d.flags[`CMVR_BIT_BCLK_MISSING] = bclk_missing;
    s_d.flags[`CMVR_BIT_BCLK_VALID] = bclk_ratio_stable
      && (bclk_ratio >= `CMVR_RATIO_MIN) && (bclk_ratio <= `CMVR_RATIO_MAX);
    // no ignore input gates this flag
    s_d.flags[`CMVR_BIT_FS_ERROR] = fs_auto_mode ? fs_rate_invalid : fs_cfg_mismatch;
    // register writes; status bits 5..0 are read-only
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        `CMVR_OFS_CLOCK_DETECT_FLAGS: s_d.flags_rsvd = reg_wdata[7:6];
        `CMVR_OFS_DIGITAL_VOLUME_LEVEL: s_d.volume_code = reg_wdata;
        `CMVR_OFS_VOLUME_RAMP_CONFIG: s_d.ramp_cfg = reg_wdata;
        default: s_d.flags_rsvd = s_q.flags_rsvd;
      endcase
    end
    // ramp engine
    if (!(falling || rising))
    begin
      s_d.tick_cnt = 2'd0;
    end
    else if (cur_int == `CMVR_INTERVAL_INSTANT)
    begin
      s_d.applied = s_q.volume_code;
      s_d.tick_cnt = 2'd0;
    end
    else if (update)
    begin
      s_d.tick_cnt = 2'd0;
      if (gap <= step)
      begin
        s_d.applied = s_q.volume_code;
      end
      else if (falling)
      begin
        s_d.applied = 8'(s_q.applied + step);
      end
      else
      begin
        s_d.applied = 8'(s_q.applied - step);
      end
    end
    else if (sample_tick)
    begin
      s_d.tick_cnt = 2'(s_q.tick_cnt + 2'd1);
    end
    s_d.ramping = (s_d.applied != s_d.volume_code);
    // read data, registered; unmapped reads zero
    unique case (reg_addr)
      `CMVR_OFS_CLOCK_DETECT_FLAGS: s_d.rdata = {s_q.flags_rsvd, s_q.flags[5:0]};
      `CMVR_OFS_DIGITAL_VOLUME_LEVEL: s_d.rdata = s_q.volume_code;
      `CMVR_OFS_VOLUME_RAMP_CONFIG: s_d.rdata = s_q.ramp_cfg;
      default: s_d.rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q.flags <= `CMVR_RST_CLOCK_DETECT_FLAGS;
      s_q.flags_rsvd <= 2'b00;
      s_q.volume_code <= `CMVR_RST_DIGITAL_VOLUME_LEVEL;
      s_q.ramp_cfg <= `CMVR_RST_VOLUME_RAMP_CONFIG;
      s_q.applied <= `CMVR_RST_DIGITAL_VOLUME_LEVEL;
      s_q.tick_cnt <= 2'd0;
      s_q.rdata <= 8'h00;
      s_q.ramping <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign applied_volume = s_q.applied;
  assign volume_ramping = s_q.ramping;

  // ==========================================================
  // assertions
  AST_BCLK_RATE: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 s_q.flags[5] == $past(bclk_rate_err)) else $error("rate flag wrong");
  AST_PLL_OVER: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 s_q.flags[4] == $past(pll_over_rate)) else $error("pll over flag wrong");
  AST_PLL_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
    !pll_enabled |=> !s_q.flags[3]) else $error("disabled pll shows locked");
  AST_BCLK_MISS: assert property (@(posedge clk) disable iff (sys_rst)
    bclk_missing |=> s_q.flags[2]) else $error("missing flag not set");
  AST_BCLK_VALID: assert property (@(posedge clk) disable iff (sys_rst)
    (!bclk_ratio_stable || bclk_ratio < 10'h020 || bclk_ratio > 10'h200) |=> !s_q.flags[1])
    else $error("invalid bit clock reported valid");
  AST_FS_ERR: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 s_q.flags[0] == ($past(fs_auto_mode) ? $past(fs_rate_invalid) : $past(fs_cfg_mismatch)))
    else $error("rate error flag wrong");
  AST_FLAGS_RO: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == 8'h39 && !bclk_missing |=> !s_q.flags[2])
    else $error("write reached read-only flag");
  AST_VOL_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == 8'h4C |=> s_q.volume_code == $past(reg_wdata))
    else $error("volume write lost");
  AST_INSTANT: assert property (@(posedge clk) disable iff (sys_rst)
    falling && fall_int == 2'b11 |=> applied_volume == $past(s_q.volume_code))
    else $error("instant fall missed");
  AST_FALL_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    falling && update && fall_int != 2'b11 && gap > step
    |=> applied_volume == 8'($past(s_q.applied) + $past(step)))
    else $error("fall step wrong");
  AST_RISE_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    rising && update && rise_int != 2'b11 && gap > step
    |=> applied_volume == 8'($past(s_q.applied) - $past(step)))
    else $error("rise step wrong");
  AST_RISE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    rising && !sample_tick && rise_int != 2'b11 |=> applied_volume == $past(s_q.applied))
    else $error("rise moved without tick");
  AST_NO_OVERSHOOT: assert property (@(posedge clk) disable iff (sys_rst)
    falling && !(reg_wr_en && reg_addr == 8'h4C) |=> applied_volume <= s_q.volume_code)
    else $error("fall overshot target");
  AST_ZERO_DB: assert property (@(posedge clk)
    sys_rst |=> applied_volume == 8'h30) else $error("reset volume not 0 dB");

  // ==========================================================
  // further flag and ramp checks
  AST_PLL_LOCK_ON: assert property (@(posedge clk) disable iff (sys_rst)
    pll_enabled && pll_locked |=> s_q.flags[3])
    else $error("locked pll shows unlocked");

  AST_MISS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    !bclk_missing |=> !s_q.flags[2])
    else $error("missing flag set without cause");

  AST_BCLK_OK: assert property (@(posedge clk) disable iff (sys_rst)
    bclk_ratio_stable && bclk_ratio >= 10'h020 && bclk_ratio <= 10'h200 |=> s_q.flags[1])
    else $error("valid bit clock reported invalid");

  AST_FS_NO_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
    fs_auto_mode && fs_rate_invalid |=> s_q.flags[0])
    else $error("rate error flag suppressed");

  AST_FLAGS_READ: assert property (@(posedge clk) disable iff (sys_rst)
    reg_addr == 8'h39 |=> reg_rdata[5:0] == $past(s_q.flags[5:0]))
    else $error("flag read differs from detectors");

  AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == 8'h39 |=> s_q.flags_rsvd == $past(reg_wdata[7:6]))
    else $error("reserved flag bits not stored");

  AST_VOL_READ: assert property (@(posedge clk) disable iff (sys_rst)
    reg_addr == 8'h4C |=> reg_rdata == $past(s_q.volume_code))
    else $error("volume read wrong");

  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == 8'h4E |=> s_q.ramp_cfg == $past(reg_wdata))
    else $error("ramp config write lost");

  AST_RESET_CFG: assert property (@(posedge clk)
    sys_rst |=> s_q.ramp_cfg == 8'h33) else $error("reset ramp config wrong");

  AST_RISE_INSTANT: assert property (@(posedge clk) disable iff (sys_rst)
    rising && rise_int == 2'b11 |=> applied_volume == $past(s_q.volume_code))
    else $error("instant rise missed");

  AST_FALL_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    falling && !sample_tick && fall_int != 2'b11 |=> applied_volume == $past(s_q.applied))
    else $error("fall moved without tick");

  AST_FALL_INTERVAL: assert property (@(posedge clk) disable iff (sys_rst)
    falling && sample_tick && fall_int == 2'b10 && s_q.tick_cnt != 2'd3
    |=> applied_volume == $past(s_q.applied))
    else $error("fall updated before fourth tick");

  AST_TICK_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
    sample_tick && (falling || rising) && !update && cur_int != 2'b11
    |=> s_q.tick_cnt == 2'($past(s_q.tick_cnt) + 2'd1))
    else $error("tick count wrong");

  AST_RISE_NO_OVERSHOOT: assert property (@(posedge clk) disable iff (sys_rst)
    rising && !(reg_wr_en && reg_addr == 8'h4C) |=> applied_volume >= s_q.volume_code)
    else $error("rise overshot target");

  AST_LAND: assert property (@(posedge clk) disable iff (sys_rst)
    (falling || rising) && update && cur_int != 2'b11 && gap <= step
    |=> applied_volume == $past(s_q.volume_code))
    else $error("last step missed target");

  AST_SETTLED: assert property (@(posedge clk) disable iff (sys_rst)
    !falling && !rising |=> applied_volume == $past(s_q.applied))
    else $error("settled volume moved");

  AST_RAMP_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    volume_ramping == (applied_volume != s_q.volume_code))
    else $error("ramping status wrong");


  COV_FALL: cover property (@(posedge clk) disable iff (sys_rst) falling ##1 update);
  COV_RISE: cover property (@(posedge clk) disable iff (sys_rst) rising ##1 update);
  COV_LAND: cover property (@(posedge clk) disable iff (sys_rst)
    volume_ramping ##1 !volume_ramping);
  COV_VALID: cover property (@(posedge clk) disable iff (sys_rst) s_q.flags[1]);
  COV_INSTANT: cover property (@(posedge clk) disable iff (sys_rst)
    falling && fall_int == 2'b11);

endmodule // cmvr_clock_monitor_volume_ramp

`default_nettype wire

/* cmvr_params.svh */
/*
  register offsets, field positions, reset values and ramp codes
  of the clock monitor and volume ramp block.
  assumes inclusion by bare name from the package and the design.
*/
`ifndef CMVR_PARAMS_SVH
`define CMVR_PARAMS_SVH

// ==========================================================
// register offsets
`define CMVR_OFS_CLOCK_DETECT_FLAGS 8'h39
`define CMVR_OFS_DIGITAL_VOLUME_LEVEL 8'h4C
`define CMVR_OFS_VOLUME_RAMP_CONFIG 8'h4E

// ==========================================================
// reset values
`define CMVR_RST_CLOCK_DETECT_FLAGS 8'h00
`define CMVR_RST_DIGITAL_VOLUME_LEVEL 8'h30
`define CMVR_RST_VOLUME_RAMP_CONFIG 8'h33

// ==========================================================
// clock detect flag bit positions
`define CMVR_BIT_BCLK_RATE_ERR 5
`define CMVR_BIT_PLL_OVER_RATE 4
`define CMVR_BIT_PLL_LOCKED 3
`define CMVR_BIT_BCLK_MISSING 2
`define CMVR_BIT_BCLK_VALID 1
`define CMVR_BIT_FS_ERROR 0
`define CMVR_FLAGS_RO_MASK 8'h3F

// ==========================================================
// volume_ramp_config field positions (low bit of each pair)
`define CMVR_POS_FALL_INTERVAL 6
`define CMVR_POS_FALL_STEP 4
`define CMVR_POS_RISE_INTERVAL 2
`define CMVR_POS_RISE_STEP 0

// ==========================================================
// codes and limits
`define CMVR_INTERVAL_INSTANT 2'b11
`define CMVR_VOL_MUTE 8'hFF
`define CMVR_VOL_0DB 8'h30
`define CMVR_RATIO_MIN 10'h020
`define CMVR_RATIO_MAX 10'h200

`endif

/* cmvr_pkg.sv */
/*
  types of the clock monitor and volume ramp block.
  assumes cmvr_params.svh is on the include path.
*/
`include "cmvr_params.svh"

package cmvr_pkg;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0] flags;
    logic [1:0] flags_rsvd;
    logic [7:0] volume_code;
    logic [7:0] ramp_cfg;
    logic [7:0] applied;
    logic [1:0] tick_cnt;
    logic [7:0] rdata;
    logic ramping;
  } cmvr_state_t;

endpackage

/* cmvr_clock_monitor_volume_ramp_tb.sv */
/*
  self-checking bench of the clock monitor and volume ramp block.
  assumes cmvr_params.svh on the include path and the design compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmvr_params.svh"

module cmvr_clock_monitor_volume_ramp_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic tick = 1'b0;
  logic [8:0] det = 9'h000;
  logic [9:0] ratio = 10'h000;
  logic [7:0] applied;
  logic ramping;
  logic [7:0] exp_vol = `CMVR_VOL_0DB;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  // ==========================================================
  // design under test
  cmvr_clock_monitor_volume_ramp i_cmvr_clock_monitor_volume_ramp (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .sample_tick(tick),
    .bclk_rate_err(det[8]), .pll_over_rate(det[7]), .pll_enabled(det[6]),
    .pll_locked(det[5]), .bclk_missing(det[4]), .bclk_ratio_stable(det[3]),
    .bclk_ratio(ratio), .fs_auto_mode(det[2]), .fs_rate_invalid(det[1]),
    .fs_cfg_mismatch(det[0]), .applied_volume(applied), .volume_ramping(ramping));

  // ==========================================================
  // compare and access tasks
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    repeat (2) @(negedge clk);
    chk8("reg_rdata", exp, rdata);
  endtask

  task automatic flag(input logic [8:0] d, input logic [9:0] r, input logic [7:0] exp);
    det = d;
    ratio = r;
    @(negedge clk);
    rd(`CMVR_OFS_CLOCK_DETECT_FLAGS, exp);
  endtask

  task automatic pulse;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic ramp(input logic [7:0] cfg, input logic [7:0] tgt);
    logic fall;
    logic [1:0] iv;
    logic [7:0] s;
    wr(`CMVR_OFS_VOLUME_RAMP_CONFIG, cfg);
    wr(`CMVR_OFS_DIGITAL_VOLUME_LEVEL, tgt);
    fall = tgt > exp_vol;
    iv = fall ? cfg[7:6] : cfg[3:2];
    s = 8'h08 >> (fall ? cfg[5:4] : cfg[1:0]);
    if (iv == `CMVR_INTERVAL_INSTANT)
    begin
      repeat (3) @(negedge clk);
      exp_vol = tgt;
    end
    while (exp_vol !== tgt)
    begin
      for (int i = 1; i < (1 << iv); i++)
      begin
        pulse();
        chk8("applied_volume", exp_vol, applied);
      end
      pulse();
      if (fall)
        exp_vol = (tgt - exp_vol > s) ? exp_vol + s : tgt;
      else
        exp_vol = (exp_vol - tgt > s) ? exp_vol - s : tgt;
      chk8("applied_volume", exp_vol, applied);
      chk1("volume_ramping", exp_vol != tgt, ramping);
    end
    chk8("applied_volume", tgt, applied);
    chk1("volume_ramping", 1'b0, ramping);
    rd(`CMVR_OFS_DIGITAL_VOLUME_LEVEL, tgt);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd(`CMVR_OFS_CLOCK_DETECT_FLAGS, 8'h00);
    rd(`CMVR_OFS_DIGITAL_VOLUME_LEVEL, 8'h30);
    rd(`CMVR_OFS_VOLUME_RAMP_CONFIG, 8'h33);
    rd(8'h40, 8'h00);
    flag(9'h100, 10'h000, 8'h20);
    flag(9'h080, 10'h000, 8'h10);
    flag(9'h060, 10'h000, 8'h08);
    flag(9'h020, 10'h000, 8'h00);
    flag(9'h010, 10'h000, 8'h04);
    flag(9'h008, 10'h020, 8'h02);
    flag(9'h008, 10'h200, 8'h02);
    flag(9'h008, 10'h01F, 8'h00);
    flag(9'h008, 10'h201, 8'h00);
    flag(9'h000, 10'h040, 8'h00);
    flag(9'h006, 10'h000, 8'h01);
    flag(9'h005, 10'h000, 8'h00);
    flag(9'h001, 10'h000, 8'h01);
    flag(9'h002, 10'h000, 8'h00);
    flag(9'h1FF, 10'h100, 8'h3F);
    wr(`CMVR_OFS_CLOCK_DETECT_FLAGS, 8'hFF);
    flag(9'h000, 10'h000, 8'hC0);
    ramp(8'h33, 8'h32);
    ramp(8'h33, 8'h30);
    ramp(8'h00, 8'h45);
    ramp(8'h55, 8'h4A);
    ramp(8'hAA, 8'h45);
    ramp(8'hCC, 8'hFF);
    ramp(8'hCC, 8'h00);
    ramp(8'h55, 8'h06);
    ramp(8'h55, 8'h00);
    ramp(8'hA0, 8'h08);
    ramp(8'hA0, 8'h00);
    rd(`CMVR_OFS_VOLUME_RAMP_CONFIG, 8'hA0);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    rd(`CMVR_OFS_DIGITAL_VOLUME_LEVEL, 8'h30);
    chk8("applied_volume", 8'h30, applied);
    rd(`CMVR_OFS_CLOCK_DETECT_FLAGS, 8'h00);
    complete_run();
  end
endmodule // cmvr_clock_monitor_volume_ramp_tb
`default_nettype wire
